// [verilog/config_wakeup_sequencer.v]
// The implementer's own choices: the placing of the registers and the APB slave port.
`include "wakeup_defs.vh"
module config_wakeup_sequencer #(
  parameter WAKE_DIV = `WAKE_DIV
) (
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire program_request_pin_n_i,
  input wire external_finish_i,
  output reg finish_pin_o,
  output reg finish_pin_oe_o,
  output reg global_output_enable_o,
  output reg global_write_enable_o,
  output reg global_set_reset_n_o,
  output reg input_accept_o,
  output reg chain_select_out_n_o,
  output reg program_pin_user_o,
  output reg io_hold_o,
  output reg [1:0] reload_access_o
);
  // ***************************************************
  // state codes
  // ***************************************************
  localparam ST_CONFIG = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_T0 = 3'h2;
  localparam ST_T1 = 3'h3;
  localparam ST_T2 = 3'h4;
  localparam ST_T3 = 3'h5;
  localparam ST_USER = 3'h6;
  // ***************************************************
  // wake-up clock enable and pin synchronisers
  // ***************************************************
  wire wake_tick;
  wake_clock_div #(
    .DIV(WAKE_DIV)
  ) u_div (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_o(wake_tick)
  );
  reg [2:0] ext_sync_q;
  reg [2:0] prog_sync_q;
  reg external_finish_sync_q;
  reg prog_level_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_sync_q <= 3'h0;
      prog_sync_q <= 3'h7;
      external_finish_sync_q <= 1'b0;
      prog_level_q <= 1'b1;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_finish_i};
      prog_sync_q <= {prog_sync_q[1:0], program_request_pin_n_i};
      if (ext_sync_q[1] == ext_sync_q[2])
        external_finish_sync_q <= ext_sync_q[2];
      if (prog_sync_q[1] == prog_sync_q[2])
        prog_level_q <= prog_sync_q[2];
    end
  end
  // ***************************************************
  // registers
  // ***************************************************
  reg [`OPT_WIDTH-1:0] options_q;
  reg [31:0] load_data_q;
  reg [31:0] user_tag_q;
  reg [15:0] serial_tag_q;
  reg [47:0] alt_start_q;
  reg [31:0] revision_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg config_done_q;
  reg config_error_q;
  reg flow_cmd_q;
  reg flow_active_q;
  reg prog_prev_q;
  wire access_w = psel_i & penable_i & pwrite_i;
  wire [1:0] chain_mode = options_q[`OPT_CHAIN_HI:`OPT_CHAIN_LO];
  wire pin_toggle = (prog_prev_q & ~prog_level_q) & ~options_q[`OPT_PIN_REUSE];
  wire ctl_wr = access_w && paddr_i == `OFS_CONTROL;
  wire reload_cmd = ctl_wr && pwdata_i[`CTL_RELOAD];
  wire restart = pin_toggle | reload_cmd;
  wire mapped = paddr_i == `OFS_OPTIONS || paddr_i == `OFS_CONTROL || paddr_i == `OFS_STATUS ||
    paddr_i == `OFS_LOAD_DATA || paddr_i == `OFS_LOAD_SEL || paddr_i == `OFS_USER_TAG ||
    paddr_i == `OFS_SERIAL_TAG || paddr_i == `OFS_ALT_START_LO || paddr_i == `OFS_ALT_START_HI ||
    paddr_i == `OFS_REVISION;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      options_q <= `OPT_RESET;
      load_data_q <= 32'h00000000;
      user_tag_q <= 32'h00000000;
      serial_tag_q <= 16'h0000;
      alt_start_q <= 48'h000000000000;
      revision_q <= 32'h00000000;
      config_done_q <= 1'b0;
      config_error_q <= 1'b0;
      flow_cmd_q <= 1'b0;
      prog_prev_q <= 1'b1;
    end else begin
      prog_prev_q <= prog_level_q;
      if (restart) begin
        config_done_q <= 1'b0;
        config_error_q <= 1'b0;
        flow_cmd_q <= 1'b0;
      end else if (ctl_wr) begin
        if (pwdata_i[`CTL_CONFIG_DONE])
          config_done_q <= 1'b1;
        if (pwdata_i[`CTL_CONFIG_ERROR])
          config_error_q <= 1'b1;
        if (pwdata_i[`CTL_FLOW_CMD])
          flow_cmd_q <= 1'b1;
      end
      if (access_w && paddr_i == `OFS_OPTIONS)
        options_q <= pwdata_i[`OPT_WIDTH-1:0];
      if (access_w && paddr_i == `OFS_LOAD_DATA)
        load_data_q <= pwdata_i;
      if (access_w && paddr_i == `OFS_LOAD_SEL) begin
        case (pwdata_i[2:0])
          `SEL_USER_TAG: begin
            user_tag_q <= load_data_q;
          end
          `SEL_SERIAL_TAG: begin
            if (options_q[`OPT_TAG_AUTO])
              serial_tag_q <= load_data_q[15:0];
          end
          `SEL_ALT_LO: begin
            alt_start_q[31:0] <= load_data_q;
          end
          `SEL_ALT_HI: begin
            alt_start_q[47:32] <= load_data_q[15:0];
          end
          `SEL_REVISION: begin
            revision_q <= load_data_q;
          end
          default: begin
            user_tag_q <= user_tag_q;
          end
        endcase
      end
    end
  end
  // user tag view: serial tag fills the upper half in auto format
  wire [31:0] tag_view = options_q[`OPT_TAG_AUTO] ? {serial_tag_q, user_tag_q[15:0]} : user_tag_q;
  // ***************************************************
  // apb read and response
  // ***************************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      pslverr_o <= ~mapped;
      prdata_o <= 32'h00000000;
      if (!pwrite_i) begin
        case (paddr_i)
          `OFS_OPTIONS: prdata_o <= {{(32-`OPT_WIDTH){1'b0}}, options_q};
          `OFS_STATUS: prdata_o <= {22'h000000, flow_active_q, external_finish_sync_q, config_error_q,
            config_done_q, 3'h0, state_q};
          `OFS_LOAD_DATA: prdata_o <= load_data_q;
          `OFS_USER_TAG: prdata_o <= tag_view;
          `OFS_SERIAL_TAG: prdata_o <= {16'h0000, serial_tag_q};
          `OFS_ALT_START_LO: prdata_o <= alt_start_q[31:0];
          `OFS_ALT_START_HI: prdata_o <= {16'h0000, alt_start_q[47:32]};
          `OFS_REVISION: prdata_o <= revision_q;
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
  // ***************************************************
  // wake-up sequencer
  // ***************************************************
  wire good_config = config_done_q & ~config_error_q;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_CONFIG: begin
        if (good_config)
          state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!options_q[`OPT_WAIT_EXT] || external_finish_sync_q)
          state_d = ST_T0;
      end
      ST_T0: state_d = ST_T1;
      ST_T1: state_d = ST_T2;
      ST_T2: state_d = options_q[`OPT_FINISH_FIRST] ? ST_USER : ST_T3;
      ST_T3: state_d = ST_USER;
      ST_USER: state_d = ST_USER;
      default: state_d = ST_CONFIG;
    endcase
  end
  wire fin_first = options_q[`OPT_FINISH_FIRST];
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_CONFIG;
      finish_pin_o <= 1'b0;
      finish_pin_oe_o <= 1'b1;
      global_output_enable_o <= 1'b0;
      global_write_enable_o <= 1'b0;
      global_set_reset_n_o <= 1'b0;
      input_accept_o <= 1'b0;
      chain_select_out_n_o <= 1'b1;
      flow_active_q <= 1'b0;
      program_pin_user_o <= 1'b0;
      io_hold_o <= 1'b0;
      reload_access_o <= `RELOAD_OFF;
    end else begin
      program_pin_user_o <= options_q[`OPT_PIN_REUSE];
      if (restart) begin
        state_q <= ST_CONFIG;
        reload_access_o <= options_q[`OPT_RELOAD_HI:`OPT_RELOAD_LO];
        io_hold_o <= options_q[`OPT_IO_HOLD];
        flow_active_q <= 1'b0;
        chain_select_out_n_o <= 1'b1;
        finish_pin_o <= 1'b0;
        input_accept_o <= 1'b0;
        if (!options_q[`OPT_IO_HOLD])
          global_output_enable_o <= 1'b0;
        global_write_enable_o <= 1'b0;
        global_set_reset_n_o <= 1'b0;
      end else begin
        if (good_config && chain_mode == `CHAIN_PASS && flow_cmd_q && state_q != ST_USER)
          flow_active_q <= 1'b1;
        else if (state_q == ST_USER)
          flow_active_q <= 1'b0;
        chain_select_out_n_o <= ~(flow_active_q && state_q != ST_USER);
        if (wake_tick) begin
          state_q <= state_d;
          case (state_q)
            ST_WAIT: begin
              if (state_d == ST_T0 && fin_first) begin
                finish_pin_o <= 1'b1;
                input_accept_o <= 1'b1;
              end
            end
            ST_T0: global_output_enable_o <= 1'b1;
            ST_T1: begin
              global_write_enable_o <= 1'b1;
              global_set_reset_n_o <= 1'b1;
            end
            ST_T2: begin
              if (!fin_first) begin
                finish_pin_o <= 1'b1;
                input_accept_o <= 1'b1;
              end
            end
            default: finish_pin_o <= finish_pin_o;
          endcase
          if (state_q == ST_USER) begin
            io_hold_o <= 1'b0;
            reload_access_o <= `RELOAD_OFF;
          end
        end
      end
    end
  end
endmodule // config_wakeup_sequencer

// [verilog/wakeup_defs.vh]
`ifndef WAKEUP_DEFS_VH
`define WAKEUP_DEFS_VH
// ***************************************************
// register byte offsets
// ***************************************************
`define OFS_OPTIONS 12'h000
`define OFS_CONTROL 12'h004
`define OFS_STATUS 12'h008
`define OFS_LOAD_DATA 12'h00c
`define OFS_LOAD_SEL 12'h010
`define OFS_USER_TAG 12'h014
`define OFS_SERIAL_TAG 12'h018
`define OFS_ALT_START_LO 12'h01c
`define OFS_ALT_START_HI 12'h020
`define OFS_REVISION 12'h024
// ***************************************************
// options fields
// ***************************************************
`define OPT_FINISH_FIRST 0
`define OPT_WAIT_EXT 1
`define OPT_CHAIN_LO 2
`define OPT_CHAIN_HI 3
`define OPT_RELOAD_LO 4
`define OPT_RELOAD_HI 5
`define OPT_PIN_REUSE 6
`define OPT_IO_HOLD 7
`define OPT_TAG_AUTO 8
`define OPT_WIDTH 9
`define OPT_RESET 9'h000
// ***************************************************
// control bits (write one sets done, error and flow until restart; reload pulses)
// ***************************************************
`define CTL_CONFIG_DONE 0
`define CTL_CONFIG_ERROR 1
`define CTL_FLOW_CMD 2
`define CTL_RELOAD 3
// ***************************************************
// chain mode and reload codes
// ***************************************************
`define CHAIN_DISABLED 2'h0
`define CHAIN_BYPASS 2'h1
`define CHAIN_PASS 2'h2
`define RELOAD_OFF 2'h0
`define RELOAD_ON 2'h1
`define RELOAD_ARRAY_ONLY 2'h2
// ***************************************************
// load selectors
// ***************************************************
`define SEL_USER_TAG 3'h0
`define SEL_SERIAL_TAG 3'h1
`define SEL_ALT_LO 3'h2
`define SEL_ALT_HI 3'h3
`define SEL_REVISION 3'h4
// ***************************************************
// timing
// ***************************************************
`define CLK_HZ 40000000
`define WAKE_CLK_HZ 1000000
`define WAKE_DIV (`CLK_HZ / `WAKE_CLK_HZ)
`endif

// [verilog/wake_clock_div.v]
`include "wakeup_defs.vh"
module wake_clock_div #(
  parameter DIV = `WAKE_DIV
) (
  input wire clock_i,
  input wire rstn_i,
  output reg tick_o
);
  reg [15:0] count_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (count_q == DIV[15:0] - 16'h0001) begin
      count_q <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      count_q <= count_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // wake_clock_div

// [tb/config_wakeup_sequencer_monitor.sv]
module config_wakeup_sequencer_monitor #(
  parameter WAKE_DIV = 40
) (
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire finish_pin_o,
  input wire finish_pin_oe_o,
  input wire global_output_enable_o,
  input wire global_write_enable_o,
  input wire global_set_reset_n_o,
  input wire chain_select_out_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // level history, one wake tick deep
  // ****
  logic [WAKE_DIV-1:0] oe_h_q, we_h_q, fin_h_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_h_q <= '0;
      we_h_q <= '0;
      fin_h_q <= '0;
    end else begin
      oe_h_q <= {oe_h_q[WAKE_DIV-2:0], global_output_enable_o};
      we_h_q <= {we_h_q[WAKE_DIV-2:0], global_write_enable_o};
      fin_h_q <= {fin_h_q[WAKE_DIV-2:0], finish_pin_o};
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  a_ready_setup: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("pready without setup");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  a_finish_drive: assert property (finish_pin_oe_o) else $error("finish pin not driven");
  a_we_sr_pair: assert property (global_write_enable_o == global_set_reset_n_o)
    else $error("write enable and set reset split");
  a_we_after_oe: assert property ($rose(global_write_enable_o) |-> oe_h_q[WAKE_DIV-1])
    else $error("write enable not one tick after output enable");
  a_oe_not_late: assert property ($rose(global_output_enable_o) |->
    !global_write_enable_o && (!finish_pin_o || fin_h_q[WAKE_DIV-1])) else $error("output enable out of order");
  a_fin_order: assert property ($rose(finish_pin_o) |-> !global_write_enable_o || we_h_q[WAKE_DIV-1])
    else $error("finish pin out of order");
  a_flow_early: assert property ($fell(chain_select_out_n_o) |-> !global_write_enable_o)
    else $error("flow started after wake");
  c_wake: cover property ($rose(global_write_enable_o));
  c_flow: cover property ($fell(chain_select_out_n_o));
  c_err: cover property (pslverr_o);
endmodule // config_wakeup_sequencer_monitor

bind config_wakeup_sequencer config_wakeup_sequencer_monitor #(.WAKE_DIV(WAKE_DIV)) mon_i (
  .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .finish_pin_o(finish_pin_o), .finish_pin_oe_o(finish_pin_oe_o),
  .global_output_enable_o(global_output_enable_o), .global_write_enable_o(global_write_enable_o),
  .global_set_reset_n_o(global_set_reset_n_o), .chain_select_out_n_o(chain_select_out_n_o));

// [tb/downstream_chain_model.sv]
module downstream_chain_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic select_n_i,
  input wire logic [7:0] delay_i,
  output logic finish_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // finish rises delay_i+1 cycles after selection and stays high
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      finish_o <= 1'b0;
    end else if (!select_n_i && !finish_o) begin
      if (cnt_q == delay_i) finish_o <= 1'b1;
      else cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // downstream_chain_model

// [tb/config_wakeup_sequencer_bench.sv]
`include "wakeup_defs.vh"
module config_wakeup_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 4;
  logic clock_i, rstn_i, psel_i, penable_i, pwrite_i, pin_n, part_rstn, pready_o, pslverr_o, ext_fin, err;
  logic fin, fin_oe, global_output_enable, global_write_enable, global_set_reset_n, acc, chain_n, pin_user, io_hold;
  logic [1:0] rl_acc;
  logic [7:0] dly;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_q, d;
  logic [31:0] m[5] = '{default: 32'h0};
  integer bad_count = 0, checks_done = 0, seed = 32'h925f, cyc = 0, tf = 0, to = 0, tw = 0, i, r;
  config_wakeup_sequencer #(.WAKE_DIV(WD)) config_wakeup_sequencer_i (.clock_i(clock_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .program_request_pin_n_i(pin_n),
    .external_finish_i(ext_fin), .finish_pin_o(fin), .finish_pin_oe_o(fin_oe), .global_output_enable_o(global_output_enable),
    .global_write_enable_o(global_write_enable), .global_set_reset_n_o(global_set_reset_n), .input_accept_o(acc),
    .chain_select_out_n_o(chain_n), .program_pin_user_o(pin_user), .io_hold_o(io_hold),
    .reload_access_o(rl_acc));
  downstream_chain_model downstream_chain_model_i (.clock_i(clock_i), .rstn_i(part_rstn),
    .select_n_i(chain_n), .delay_i(dly), .finish_o(ext_fin));
  initial begin
    clock_i = 0;
    forever #12.5 clock_i = ~clock_i;
  end
  // rise times of the phase outputs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if ($rose(fin)) tf <= cyc;
    if ($rose(global_output_enable)) to <= cyc;
    if ($rose(global_write_enable)) tw <= cyc;
  end
  // ****
  // helpers
  // ****
  task automatic test_done;
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dv);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dv;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd_q = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd_q, e);
  endtask
  task automatic go_user;
    for (int k = 0; k < 60; k++) begin
      apb(0, `OFS_STATUS, 0);
      if (rd_q[2:0] === 3'h6) break;
    end
    chk(rd_q[2:0], 3'h6);
  endtask
  function automatic logic [31:0] opt(input logic ff, we, input logic [1:0] ch, rl, input logic ru, ho, au);
    opt = {23'h0, au, ho, ru, rl, ch, we, ff};
  endfunction
  function automatic logic [31:0] exp_reg(input int k, input logic au);
    exp_reg = (k == 0 && au) ? {m[1][15:0], m[0][15:0]} : m[k];
  endfunction
  function automatic integer fin_ofs(input logic ff);
    fin_ofs = ff ? -WD : 2 * WD;
  endfunction
  initial begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    test_done;
  end
  // ****
  // scenarios
  // ****
  initial begin
    {rstn_i, part_rstn, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pin_n = 1;
    dly = 8'h02;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1;
    part_rstn <= 1;
    @(posedge clock_i);
    chk({global_set_reset_n, global_write_enable, global_output_enable, fin, chain_n, io_hold, pin_user, rl_acc, fin_oe}, 10'h021);
    rd(`OFS_OPTIONS, `OPT_RESET);
    apb(0, 12'h100, 0);
    chk({err, rd_q}, {1'b1, 32'h0});
    for (r = 0; r < 2; r++) begin
      apb(1, `OFS_OPTIONS, opt(0, 0, 0, 0, 0, 0, r[0]));
      for (i = 0; i < 5; i++) begin
        d = $random(seed);
        apb(1, `OFS_LOAD_DATA, d);
        apb(1, `OFS_LOAD_SEL, i);
        if (i != 1 || r) m[i] = (i == 1 || i == 3) ? d[15:0] : d;
      end
      apb(1, `OFS_USER_TAG, $random(seed));
      for (i = 0; i < 5; i++) rd(12'(`OFS_USER_TAG + 4 * i), exp_reg(i, r[0]));
    end
    apb(1, `OFS_CONTROL, 32'h8);
    apb(1, `OFS_OPTIONS, 0);
    apb(1, `OFS_CONTROL, 32'h3);
    repeat (6 * WD) @(posedge clock_i);
    chk({fin, global_output_enable}, 0);
    for (r = 0; r < 2; r++) begin
      apb(1, `OFS_CONTROL, 32'h8);
      apb(1, `OFS_OPTIONS, opt(r[0], 0, 0, 0, 0, 0, 0));
      repeat (3 * WD) @(posedge clock_i);
      chk(global_output_enable, 0);
      apb(1, `OFS_CONTROL, 32'h1);
      go_user;
      chk(tw - to, WD);
      chk(tf - to, fin_ofs(r[0]));
      chk({global_set_reset_n, global_write_enable, global_output_enable, fin, acc}, 5'h1f);
    end
    part_rstn <= 0;
    dly <= 8'd40;
    @(posedge clock_i);
    part_rstn <= 1;
    apb(1, `OFS_CONTROL, 32'h8);
    apb(1, `OFS_OPTIONS, opt(0, 1, `CHAIN_PASS, 0, 0, 0, 0));
    apb(1, `OFS_CONTROL, 32'h5);
    repeat (4) @(posedge clock_i);
    chk(chain_n, 0);
    repeat (20) @(posedge clock_i);
    chk({global_output_enable, ext_fin}, 0);
    go_user;
    chk({chain_n, global_output_enable}, 2'h3);
    for (r = 0; r < 3; r++) begin
      apb(1, `OFS_CONTROL, 32'h8);
      apb(1, `OFS_OPTIONS, opt(1, 0, r[1:0], r[1:0], r[1], r[0], 0));
      apb(1, `OFS_CONTROL, 32'h1);
      go_user;
      chk({pin_user, chain_n}, {r[1], 1'b1});
      if (r[1]) apb(1, `OFS_CONTROL, 32'h8);
      else begin
        pin_n <= 0;
        repeat (6) @(posedge clock_i);
        pin_n <= 1;
      end
      repeat (2) @(posedge clock_i);
      chk({rl_acc, io_hold, global_output_enable}, {r[1:0], r[0], r[0]});
    end
    test_done;
  end
endmodule // config_wakeup_sequencer_bench
